/* fifo2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock
// Notes:   Flush empties it at once
`timescale 1ns/1ns
module fifo2 #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_flush,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);

  logic [W-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rd_q];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // Pointers and fill count
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (i_flush)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wr_q <= wr_q ^ push;
      rd_q <= rd_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_data;
    end
  end

endmodule

/* pin_sync.sv */
// Purpose: Two-stage synchroniser with edge detection for pin inputs
// Assumes: Pins are asynchronous to i_mclk
// Notes:   Edges come from the second and third stages only
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Pins and results
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Synchroniser chain
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level and edges
  assign o_level = s2_q;
  assign o_rise = s2_q & ~s3_q;
  assign o_fall = ~s2_q & s3_q;

endmodule

/* prog_port.sv */
// Purpose: Parallel and serial programming port of the nonvolatile memories
// Assumes: All pin inputs asynchronous; i_mclk at 100 MHz
// Notes:   Operation
`timescale 1ns/1ns
module prog_port
  import prog_port_pkg::*;
#(
  parameter int unsigned FLASH_AW = 14,
  parameter int unsigned EE_AW = 10,
  parameter int unsigned FLASH_WD = prog_port_pkg::FLASH_WD_CYC,
  parameter int unsigned EEPROM_WD = prog_port_pkg::EEPROM_WD_CYC,
  parameter int unsigned ERASE_WD = prog_port_pkg::ERASE_WD_CYC,
  parameter logic [7:0] FUSE_LO_INIT = 8'hff,
  parameter logic [7:0] FUSE_HI_INIT = 8'hff,
  parameter logic [7:0] FUSE_EX_INIT = 8'hff,
  parameter logic [7:0] ID0 = 8'h5a, // Identification values are arbitrary
  parameter logic [7:0] ID1 = 8'h3c,
  parameter logic [7:0] ID2 = 8'h0f,
  parameter logic [7:0] CALIB = 8'h80
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Parallel port
  input wire logic i_parallel_mode,
  input wire logic i_oscillator_input,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic i_page_buffer_latch,
  input wire logic i_action_select_high,
  input wire logic i_action_select_low,
  input wire logic i_byte_select_lo,
  input wire logic i_byte_select_hi,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_ready_busy_flag,
  // Serial port
  input wire logic i_reset_n,
  input wire logic i_sck,
  input wire logic i_serial_program_in,
  output logic o_serial_program_out
);

  // ----------------------------------------
  // Checks and storage
  // ----------------------------------------
  if (FLASH_AW < 8 || FLASH_AW > 16 || EE_AW < 1 || EE_AW > 12)
  begin : g_bad_aw
    $error("prog_port: address width out of range");
  end
  if (ERASE_WD < (1 << FLASH_AW) || ERASE_WD < (1 << EE_AW) || FLASH_WD < 128)
  begin : g_bad_wd
    $error("prog_port: write delay too short to walk the arrays");
  end
  if (EEPROM_WD >= (1 << 20) || ERASE_WD >= (1 << 20) || FLASH_WD >= (1 << 20))
  begin : g_bad_cnt
    $error("prog_port: write delay too long for the busy counter");
  end

  logic [15:0] flash_q [1 << FLASH_AW];
  logic [7:0] ee_q [1 << EE_AW];
  logic [7:0] pg_lo_q [1 << PAGE_AW];
  logic [7:0] pg_hi_q [1 << PAGE_AW];
  logic [7:0] lock_q;

  // Identification byte by low address
  function automatic logic [7:0] id_byte(input logic [1:0] sel);
    case (sel)
      2'h0: id_byte = ID0;
      2'h1: id_byte = ID1;
      2'h2: id_byte = ID2;
      default: id_byte = 8'hff;
    endcase
  endfunction

  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;
  logic [7:0] din;
  logic par;
  logic ser;

  pin_sync #(.W(PIN_W)) u_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_pin({i_data, i_byte_select_hi, i_byte_select_lo, i_action_select_high,
            i_action_select_low, i_parallel_mode, i_reset_n, i_serial_program_in,
            i_sck, i_page_buffer_latch, i_oe_n, i_wr_n, i_oscillator_input}),
    .o_level(lvl),
    .o_rise(rise),
    .o_fall(fall)
  );

  assign din = lvl[PIN_DATA +: 8];
  assign par = lvl[PIN_PAR];
  assign ser = ~lvl[PIN_PAR] & ~lvl[PIN_RST_N];

  // ----------------------------------------
  // Parallel loads
  // ----------------------------------------
  logic [7:0] cmd_q;
  logic [15:0] addr_q;
  logic [7:0] dlo_q;
  logic [7:0] dhi_q;
  logic [1:0] act;

  assign act = {lvl[PIN_XA1], lvl[PIN_XA0]};

  // Command, address and data latches on oscillator rise
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cmd_q <= 8'h00;
      addr_q <= 16'h0000;
      dlo_q <= 8'hff;
      dhi_q <= 8'hff;
    end
    else if (par && rise[PIN_OSC])
    begin
      case (act)
        ACT_CMD: cmd_q <= din;
        ACT_ADDR:
        begin
          if (lvl[PIN_BS1])
            addr_q[15:8] <= din;
          else
            addr_q[7:0] <= din;
        end
        ACT_DATA:
        begin
          if (lvl[PIN_BS1])
            dhi_q <= din;
          else
            dlo_q <= din;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Serial shifter
  // ----------------------------------------
  logic [31:0] rx_q;
  logic [31:0] rx_nx;
  logic [4:0] bit_q;
  logic [7:0] tx_q;
  logic spo_q;
  logic pe_q;
  logic [7:0] rd_byte;
  logic byte_done;
  logic bv;
  logic [7:0] bd;
  logic b_rdy;
  logic tx_load;

  assign rx_nx = {rx_q[30:0], lvl[PIN_MOSI]};
  assign byte_done = ser & rise[PIN_SCK] & (bit_q[2:0] == 3'h7) & (bit_q != 5'h1f);
  assign tx_load = ser & fall[PIN_SCK] & (bit_q[2:0] == 3'h0);

  // Input bits on clock rise, MSB first
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rx_q <= 32'h0000_0000;
      bit_q <= 5'h00;
    end
    else if (!ser)
    begin
      bit_q <= 5'h00;
    end
    else if (rise[PIN_SCK])
    begin
      rx_q <= rx_nx;
      bit_q <= bit_q + 5'h01;
    end
  end

  // Outgoing bytes: previous byte echoed, read data in the fourth
  always_comb
  begin
    rd_byte = rx_nx[7:0];
    if (bit_q == 5'h17)
    begin
      if ((rx_nx[23:16] & 8'hf7) == SER_RD_FLASH)
        rd_byte = rx_nx[19] ? flash_q[rx_nx[FLASH_AW-1:0]][15:8]
                            : flash_q[rx_nx[FLASH_AW-1:0]][7:0];
      else if (rx_nx[23:16] == SER_RD_EE)
        rd_byte = ee_q[rx_nx[EE_AW-1:0]];
      else if (rx_nx[23:16] == SER_RD_LOCK)
        rd_byte = lock_q;
      else if (rx_nx[23:16] == SER_RD_SIG)
        rd_byte = id_byte(rx_nx[1:0]);
    end
  end

  fifo2 #(.W(8)) u_txbuf (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_flush(~ser),
    .i_valid(byte_done),
    .i_data(rd_byte),
    .o_ready(b_rdy),
    .o_valid(bv),
    .o_data(bd),
    .i_ready(tx_load)
  );

  // Output bits on clock fall
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tx_q <= 8'h00;
      spo_q <= 1'b0;
    end
    else if (!ser)
    begin
      tx_q <= 8'h00;
      spo_q <= 1'b0;
    end
    else if (fall[PIN_SCK])
    begin
      if (tx_load && bv)
      begin
        spo_q <= bd[7];
        tx_q <= {bd[6:0], 1'b0};
      end
      else
      begin
        spo_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic busy_q;
  op_t op_q;
  op_t req;
  logic [15:0] req_addr;
  logic [7:0] req_data;
  logic ser_exec;
  logic par_wr;
  logic [7:0] b1;
  logic [7:0] b2;

  assign b1 = rx_nx[31:24];
  assign b2 = rx_nx[23:16];
  assign ser_exec = ser & rise[PIN_SCK] & (bit_q == 5'h1f) & pe_q & ~busy_q;
  assign par_wr = par & fall[PIN_WR_N] & ~busy_q;

  always_comb
  begin
    req = OP_NONE;
    req_addr = addr_q;
    req_data = dlo_q;
    if (par_wr)
    begin
      case (cmd_q)
        CMD_CHIP_ERASE: req = OP_ERASE;
        CMD_WR_FLASH: req = OP_PAGE;
        CMD_WR_EEPROM: req = OP_EEWR;
        CMD_WR_LOCK: req = OP_LOCK;
        CMD_WR_FUSE:
        begin
          case ({lvl[PIN_BS2], lvl[PIN_BS1]})
            2'b00: req = OP_FUSE_LO;
            2'b01: req = OP_FUSE_HI;
            2'b10: req = OP_FUSE_EX;
            default: req = OP_NONE;
          endcase
        end
        default: req = OP_NONE;
      endcase
    end
    else if (ser_exec)
    begin
      req_addr = rx_nx[23:8];
      req_data = rx_nx[7:0];
      if (b1 == SER_WR_PAGE)
        req = OP_PAGE;
      else if (b1 == SER_WR_EE)
        req = OP_EEWR;
      else if (b1 == SER_PE_B1 && b2[7:5] == 3'b100)
        req = OP_ERASE;
      else if (b1 == SER_PE_B1 && b2[7:5] == 3'b111)
        req = OP_LOCK;
      else if (b1 == SER_PE_B1 && b2 == SER_FUSE_LO)
        req = OP_FUSE_LO;
      else if (b1 == SER_PE_B1 && b2 == SER_FUSE_HI)
        req = OP_FUSE_HI;
    end
  end

  // Serial enable: set by the enable instruction, cleared when reset rises
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pe_q <= 1'b0;
    else if (!ser)
      pe_q <= 1'b0;
    else if (rise[PIN_SCK] && bit_q == 5'h1f && b1 == SER_PE_B1 && b2 == SER_PE_B2)
      pe_q <= 1'b1;
  end

  // ----------------------------------------
  // Fuses, lock bits and busy timer
  // ----------------------------------------
  logic [7:0] fuse_lo_q;
  logic [7:0] fuse_hi_q;
  logic [7:0] fuse_ex_q;
  logic [19:0] cnt_q;
  logic [19:0] walk_q;
  logic [15:0] base_q;
  logic [7:0] lock_wr;

  // Boot lock bits stay as they are once mode 3 is set
  assign lock_wr = (lock_q[1:0] == 2'b00) ? (req_data | 8'h3c) : req_data;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fuse_lo_q <= FUSE_LO_INIT;
      fuse_hi_q <= FUSE_HI_INIT;
      fuse_ex_q <= FUSE_EX_INIT;
      lock_q <= LOCK_RESET;
      busy_q <= 1'b0;
      op_q <= OP_NONE;
      cnt_q <= 20'h00000;
      walk_q <= 20'h00000;
      base_q <= 16'h0000;
    end
    else if (busy_q)
    begin
      walk_q <= walk_q + 20'h00001;
      cnt_q <= cnt_q - 20'h00001;
      if (cnt_q == 20'h00001)
      begin
        busy_q <= 1'b0;
        if (op_q == OP_ERASE)
          lock_q <= LOCK_RESET;
      end
    end
    else if (req != OP_NONE)
    begin
      busy_q <= 1'b1;
      op_q <= req;
      walk_q <= 20'h00000;
      base_q <= req_addr;
      case (req)
        OP_FUSE_LO: fuse_lo_q <= req_data;
        OP_FUSE_HI: fuse_hi_q <= req_data;
        OP_FUSE_EX: fuse_ex_q <= req_data;
        OP_LOCK: lock_q <= lock_q & lock_wr;
        default: ;
      endcase
      case (req)
        OP_ERASE: cnt_q <= 20'(ERASE_WD);
        OP_EEWR: cnt_q <= 20'(EEPROM_WD);
        default: cnt_q <= 20'(FLASH_WD);
      endcase
    end
  end

  // ----------------------------------------
  // Array writes
  // ----------------------------------------
  logic [FLASH_AW-1:0] pg_dst;

  assign pg_dst = {base_q[FLASH_AW-1:PAGE_AW], walk_q[PAGE_AW-1:0]};

  // Page buffer fill from either port
  always_ff @(posedge i_mclk)
  begin
    if (par && rise[PIN_PAGE_BUFFER_LATCH] && cmd_q == CMD_WR_FLASH)
    begin
      pg_lo_q[addr_q[PAGE_AW-1:0]] <= dlo_q;
      pg_hi_q[addr_q[PAGE_AW-1:0]] <= dhi_q;
    end
    else if (ser && rise[PIN_SCK] && bit_q == 5'h1f && pe_q && (b1 & 8'hf7) == SER_LD_PAGE)
    begin
      if (b1[3])
        pg_hi_q[rx_nx[14:8]] <= rx_nx[7:0];
      else
        pg_lo_q[rx_nx[14:8]] <= rx_nx[7:0];
    end
  end

  // Erase walk, page copy and EEPROM byte write
  always_ff @(posedge i_mclk)
  begin
    if (busy_q && op_q == OP_ERASE)
    begin
      if (walk_q < 20'(1 << FLASH_AW))
        flash_q[walk_q[FLASH_AW-1:0]] <= 16'hffff;
      if (walk_q < 20'(1 << EE_AW))
        ee_q[walk_q[EE_AW-1:0]] <= 8'hff;
    end
    else if (busy_q && op_q == OP_PAGE && walk_q < 20'(1 << PAGE_AW))
    begin
      flash_q[pg_dst] <= {pg_hi_q[walk_q[PAGE_AW-1:0]], pg_lo_q[walk_q[PAGE_AW-1:0]]};
    end
    else if (!busy_q && req == OP_EEWR)
    begin
      ee_q[req_addr[EE_AW-1:0]] <= req_data;
    end
  end

  // ----------------------------------------
  // Parallel read and outputs
  // ----------------------------------------
  logic [7:0] par_rd;
  logic [7:0] data_q;
  logic oe_q;
  logic rb_q;
  logic so_q;

  always_comb
  begin
    case (cmd_q)
      CMD_RD_EEPROM: par_rd = ee_q[addr_q[EE_AW-1:0]];
      CMD_RD_FLASH: par_rd = lvl[PIN_BS1] ? flash_q[addr_q[FLASH_AW-1:0]][15:8]
                                          : flash_q[addr_q[FLASH_AW-1:0]][7:0];
      CMD_RD_ID: par_rd = lvl[PIN_BS1] ? CALIB : id_byte(addr_q[1:0]);
      CMD_RD_FUSE_LOCK:
      begin
        case ({lvl[PIN_BS2], lvl[PIN_BS1]})
          2'b00: par_rd = fuse_lo_q;
          2'b11: par_rd = fuse_hi_q;
          2'b10: par_rd = fuse_ex_q;
          default: par_rd = lock_q;
        endcase
      end
      default: par_rd = 8'hff;
    endcase
  end

  // Registered pin drivers
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      data_q <= 8'h00;
      oe_q <= 1'b0;
      rb_q <= 1'b1;
      so_q <= 1'b0;
    end
    else
    begin
      oe_q <= par & ~lvl[PIN_OE_N];
      data_q <= par_rd;
      rb_q <= ~busy_q & ~(req != OP_NONE);
      so_q <= spo_q;
    end
  end

  assign o_data = data_q;
  assign o_data_oe = oe_q;
  assign o_ready_busy_flag = rb_q;
  assign o_serial_program_out = so_q;

endmodule

/* prog_port_asserts.sv */
// Purpose: Port checks for the programming port
// Assumes: One clock domain, write delays all equal to WD
// Notes:   Bound to every prog_port instance
`timescale 1ns/1ns
module prog_port_asserts #(
  parameter int unsigned WD = 300
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Watched ports
  input wire logic i_parallel_mode,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic i_reset_n,
  input wire logic i_sck,
  input wire logic o_data_oe,
  input wire logic o_ready_busy_flag,
  input wire logic o_serial_program_out
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] busy_q;
  // Length of the current busy phase
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      busy_q <= '0;
    else if (o_ready_busy_flag)
      busy_q <= '0;
    else
      busy_q <= busy_q + 16'h1;
  end
  busy_min_a: assert property ($rose(o_ready_busy_flag) |-> busy_q >= WD)
    else $error("busy phase too short");
  busy_max_a: assert property (busy_q <= WD + 3)
    else $error("busy phase too long");
  busy_hold_a: assert property ($fell(o_ready_busy_flag) |-> !o_ready_busy_flag [*8])
    else $error("busy dropped early");
  idle_ready_a: assert property
    ((i_parallel_mode && i_wr_n && o_ready_busy_flag) [*8] |=> o_ready_busy_flag)
    else $error("busy without a strobe");
  oe_off_a: assert property (i_oe_n [*8] |-> !o_data_oe)
    else $error("bus driven with read off");
  oe_serial_a: assert property (!i_parallel_mode [*8] |-> !o_data_oe)
    else $error("bus driven in serial mode");
  oe_on_a: assert property ((i_parallel_mode && !i_oe_n) [*8] |-> o_data_oe)
    else $error("bus not driven on read");
  out_stable_a: assert property
    ((i_sck && !i_reset_n && !i_parallel_mode) [*8] |-> $stable(o_serial_program_out))
    else $error("serial out moved in high phase");
  cover property (o_data_oe);
  cover property ($rose(o_ready_busy_flag));
  cover property (!i_reset_n && $changed(o_serial_program_out));
endmodule
bind prog_port prog_port_asserts #(.WD(FLASH_WD)) chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_parallel_mode(i_parallel_mode), .i_wr_n(i_wr_n), .i_oe_n(i_oe_n), .i_reset_n(i_reset_n),
  .i_sck(i_sck), .o_data_oe(o_data_oe), .o_ready_busy_flag(o_ready_busy_flag),
  .o_serial_program_out(o_serial_program_out));

/* prog_port_pkg.sv */
// Purpose: Shared constants for the external memory programming port
// Assumes: 100 MHz core clock
// Notes:   Times are in ns; cycle counts derive from the clock period
package prog_port_pkg;

  // ----------------------------------------
  // Clock and wait times
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_FLASH_WD_NS = 4500000;
  localparam int unsigned T_EEPROM_WD_NS = 9000000;
  localparam int unsigned T_ERASE_WD_NS = 9000000;
  localparam int unsigned FLASH_WD_CYC = (T_FLASH_WD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EEPROM_WD_CYC = (T_EEPROM_WD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_WD_CYC = (T_ERASE_WD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Parallel commands and action selects
  // ----------------------------------------
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_ID = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  // ----------------------------------------
  // Serial instruction bytes
  // ----------------------------------------
  localparam logic [7:0] SER_PE_B1 = 8'hac;
  localparam logic [7:0] SER_PE_B2 = 8'h53;
  localparam logic [7:0] SER_RD_FLASH = 8'h20;
  localparam logic [7:0] SER_LD_PAGE = 8'h40;
  localparam logic [7:0] SER_WR_PAGE = 8'h4c;
  localparam logic [7:0] SER_RD_EE = 8'ha0;
  localparam logic [7:0] SER_WR_EE = 8'hc0;
  localparam logic [7:0] SER_RD_LOCK = 8'h58;
  localparam logic [7:0] SER_RD_SIG = 8'h30;
  localparam logic [7:0] SER_FUSE_LO = 8'ha0;
  localparam logic [7:0] SER_FUSE_HI = 8'ha8;
  localparam int unsigned PAGE_AW = 7;

  // ----------------------------------------
  // Reset values and synchroniser bit positions
  // ----------------------------------------
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam int unsigned PIN_OSC = 0;
  localparam int unsigned PIN_WR_N = 1;
  localparam int unsigned PIN_OE_N = 2;
  localparam int unsigned PIN_PAGE_BUFFER_LATCH = 3;
  localparam int unsigned PIN_SCK = 4;
  localparam int unsigned PIN_MOSI = 5;
  localparam int unsigned PIN_RST_N = 6;
  localparam int unsigned PIN_PAR = 7;
  localparam int unsigned PIN_XA0 = 8;
  localparam int unsigned PIN_XA1 = 9;
  localparam int unsigned PIN_BS1 = 10;
  localparam int unsigned PIN_BS2 = 11;
  localparam int unsigned PIN_DATA = 12;
  localparam int unsigned PIN_W = 20;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ERASE = 3'b001,
    OP_PAGE = 3'b010,
    OP_EEWR = 3'b011,
    OP_FUSE_LO = 3'b100,
    OP_FUSE_HI = 3'b101,
    OP_FUSE_EX = 3'b110,
    OP_LOCK = 3'b111
  } op_t;

endpackage

/* serial_programmer.sv */
// Purpose: Programmer side of the serial link
// Assumes: 160 ns link clock, idle low between frames
// Notes:   Data in toggles when idle so no stale level is seen
`timescale 1ns/1ns
module serial_programmer (
  // Link pins
  output logic o_sck,
  output logic o_mosi,
  output logic o_reset_n,
  input wire logic i_miso
);
  // Power up with reset and clock low
  initial
  begin
    o_sck = 1'b0;
    o_reset_n = 1'b0;
    o_mosi = 1'b0;
  end
  // One four-byte instruction, MSB first
  task automatic xfer(input logic [31:0] ins, output logic [31:0] rsp);
    #1; // Keep link edges off the sampling edge
    for (int i = 31; i >= 0; i--)
    begin
      o_mosi = ins[i];
      #80;
      rsp = {rsp[30:0], i_miso};
      o_sck = 1'b1;
      #80;
      o_sck = 1'b0;
    end
    o_mosi = ~o_mosi;
  endtask
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the programming port
// Assumes: Shortened write delays of 300 cycles
// Notes:   Fuse and lock writes first, then table reads, then lock, erase and serial cases
`timescale 1ns/1ns
module testbench;
  import prog_port_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [7:0] adr; logic [1:0] sel; logic [7:0] exp;} row_t;
  logic mclk = 1'b0, arst_n = 1'b0, par = 1'b1, osc = 1'b0, wr_n = 1'b1, oe_n = 1'b1;
  logic pgl = 1'b0;
  logic act_hi = 1'b0, act_lo = 1'b0, bsel_lo = 1'b0, bsel_hi = 1'b0;
  logic [7:0] din = 8'h00, dout, v;
  logic doe, rdy, rst_n, sck, mosi, miso;
  logic [31:0] r;
  int errors = 0, n_compared = 0;
  row_t rows [8] = '{'{CMD_RD_FUSE_LOCK, 8'h00, 2'h0, 8'he2}, '{CMD_RD_FUSE_LOCK, 8'h00, 2'h3, 8'h99},
    '{CMD_RD_FUSE_LOCK, 8'h00, 2'h2, 8'hfd}, '{CMD_RD_FUSE_LOCK, 8'h00, 2'h1, 8'hfc},
    '{CMD_RD_ID, 8'h00, 2'h0, 8'h5a}, '{CMD_RD_ID, 8'h01, 2'h0, 8'h3c},
    '{CMD_RD_ID, 8'h02, 2'h0, 8'h0f}, '{CMD_RD_ID, 8'h00, 2'h1, 8'h80}};
  always #5 mclk = ~mclk;
  serial_programmer prg (.o_sck(sck), .o_mosi(mosi), .o_reset_n(rst_n), .i_miso(miso));
  // Identity rows expect the arbitrary default identity values
  prog_port #(.FLASH_AW(8), .EE_AW(4), .FLASH_WD(300), .EEPROM_WD(300), .ERASE_WD(300))
    dut (.i_mclk(mclk), .i_arst_n(arst_n),
    .i_parallel_mode(par), .i_oscillator_input(osc), .i_wr_n(wr_n), .i_oe_n(oe_n),
    .i_page_buffer_latch(pgl), .i_action_select_high(act_hi), .i_action_select_low(act_lo),
    .i_byte_select_lo(bsel_lo), .i_byte_select_hi(bsel_hi), .i_data(din), .o_data(dout),
    .o_data_oe(doe), .o_ready_busy_flag(rdy), .i_reset_n(rst_n), .i_sck(sck),
    .i_serial_program_in(mosi), .o_serial_program_out(miso));
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Load one byte on an oscillator pulse
  task automatic load(input logic [1:0] act, input logic sl, input logic [7:0] d);
    act_hi <= act[1];
    act_lo <= act[0];
    bsel_lo <= sl;
    din <= d;
    repeat (4) @(posedge mclk);
    osc <= 1'b1;
    repeat (4) @(posedge mclk);
    osc <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // Bounded wait for ready
  task automatic wait_rdy();
    int n;
    repeat (8) @(posedge mclk);
    for (n = 0; n < 400 && rdy !== 1'b1; n++)
      @(posedge mclk);
    if (n == 400)
    begin
      errors++;
      give_verdict();
    end
  endtask
  // Write strobe with selects {hi, lo}
  task automatic wr(input logic [1:0] sel);
    {bsel_hi, bsel_lo} <= sel;
    repeat (4) @(posedge mclk);
    wr_n <= 1'b0;
    repeat (4) @(posedge mclk);
    wr_n <= 1'b1;
    wait_rdy();
    {bsel_hi, bsel_lo} <= 2'h0;
  endtask
  // Read the bus with selects {hi, lo}
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    {bsel_hi, bsel_lo} <= sel;
    oe_n <= 1'b0;
    repeat (8) @(posedge mclk);
    d = dout;
    chk({7'h0, doe}, 8'h01);
    oe_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({6'h00, rdy, doe}, 8'h02);
    load(ACT_ADDR, 1'b1, 8'h00);
    load(ACT_CMD, 1'b0, CMD_WR_FUSE);
    load(ACT_DATA, 1'b0, 8'he2);
    wr(2'h0);
    load(ACT_DATA, 1'b0, 8'h99);
    wr(2'h1);
    load(ACT_DATA, 1'b0, 8'hfd);
    wr(2'h2);
    load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    load(ACT_DATA, 1'b0, 8'hfc);
    wr(2'h0);
    foreach (rows[i])
    begin
      load(ACT_CMD, 1'b0, rows[i].cmd);
      load(ACT_ADDR, 1'b0, rows[i].adr);
      rd(rows[i].sel, v);
      chk(v, rows[i].exp);
    end
    // Boot lock refused in mode 3, no unprogramming
    load(ACT_CMD, 1'b0, CMD_WR_LOCK);
    load(ACT_DATA, 1'b0, 8'hc3);
    wr(2'h0);
    load(ACT_DATA, 1'b0, 8'hff);
    wr(2'h0);
    load(ACT_CMD, 1'b0, CMD_RD_FUSE_LOCK);
    rd(2'h1, v);
    chk(v, 8'hfc);
    load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
    wr(2'h0);
    load(ACT_CMD, 1'b0, CMD_RD_FUSE_LOCK);
    rd(2'h1, v);
    chk(v, 8'hff);
    load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
    load(ACT_ADDR, 1'b0, 8'h05);
    rd(2'h0, v);
    chk(v, 8'hff);
    load(ACT_CMD, 1'b0, CMD_WR_EEPROM);
    load(ACT_DATA, 1'b0, 8'h66);
    wr(2'h0);
    load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
    rd(2'h0, v);
    chk(v, 8'h66);
    // Parallel page: word 3 through the page buffer, then both bytes back
    load(ACT_CMD, 1'b0, CMD_WR_FLASH);
    load(ACT_ADDR, 1'b0, 8'h03);
    load(ACT_DATA, 1'b0, 8'h34);
    load(ACT_DATA, 1'b1, 8'h12);
    pgl <= 1'b1;
    repeat (4) @(posedge mclk);
    pgl <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(2'h0);
    load(ACT_CMD, 1'b0, CMD_RD_FLASH);
    rd(2'h0, v);
    chk(v, 8'h34);
    rd(2'h1, v);
    chk(v, 8'h12);
    // Serial session: shortened power-up wait, write refused before enable
    par <= 1'b0;
    repeat (20) @(posedge mclk);
    prg.xfer({SER_WR_EE, 8'h00, 8'h05, 8'ha5}, r);
    wait_rdy();
    prg.xfer({SER_PE_B1, SER_PE_B2, 16'h0000}, r);
    chk(r[15:8], SER_PE_B2);
    prg.xfer({SER_RD_EE, 8'h00, 8'h05, 8'h00}, r);
    chk(r[7:0], 8'h66);
    prg.xfer({SER_RD_SIG, 8'h00, 8'h01, 8'h00}, r);
    chk(r[7:0], 8'h3c);
    prg.xfer({SER_RD_LOCK, 24'h000000}, r);
    chk(r[7:0], 8'hff);
    prg.xfer({SER_LD_PAGE, 8'h00, 8'h02, 8'h78}, r);
    prg.xfer({SER_LD_PAGE | 8'h08, 8'h00, 8'h02, 8'h56}, r);
    prg.xfer({SER_WR_PAGE, 24'h000000}, r);
    wait_rdy();
    prg.xfer({SER_RD_FLASH | 8'h08, 8'h00, 8'h02, 8'h00}, r);
    chk(r[7:0], 8'h56);
    foreach (rows[i])
    begin
      if (i < 2)
      begin
        prg.xfer({SER_WR_EE, 8'h00, 8'h05, rows[i + 1].exp}, r);
        wait_rdy();
        prg.xfer({SER_RD_EE, 8'h00, 8'h05, 8'h00}, r);
        chk(r[7:0], rows[i + 1].exp);
      end
    end
    give_verdict();
  end
endmodule
